//--- core/dwps_consts.svh
`ifndef DWPS_CONSTS_SVH
`define DWPS_CONSTS_SVH

// Sample code width and on-board queue depth in samples
`define DWPS_SAMPLE_W      16
`define DWPS_FIFO_DEPTH    10240

// System clock and waveform timebase, in MHz
`define DWPS_SYS_MHZ       200
`define DWPS_TB_MHZ        80
`define DWPS_ACC_W         9

// Smallest legal update interval, in timebase periods
`define DWPS_MIN_INTERVAL  32'h0000_0050

// Shortest external trigger pulse and the system period, in ns
`define DWPS_TRIG_MIN_NS   20
`define DWPS_SYS_PERIOD_NS 5
`define DWPS_TRIG_MIN_CYC  ((`DWPS_TRIG_MIN_NS + `DWPS_SYS_PERIOD_NS - 1) / `DWPS_SYS_PERIOD_NS)
// Samples a new level must hold, allowing one lost to synchroniser phase
`define DWPS_TRIG_FILT_CYC (`DWPS_TRIG_MIN_CYC - 1)
`define DWPS_FILT_W        3

`endif

//--- core/dwps_pkg.sv
`include "dwps_consts.svh"

package dwps_pkg;

  // Signed converter code: 0x8000 full negative, 0x7fff full scale less one step
  typedef logic signed [`DWPS_SAMPLE_W-1:0] dwps_code_type;

  // Sequence state
  typedef enum logic [1:0] {
    DW_IDLE,
    DW_DELAY1,
    DW_RUN,
    DW_DELAY2
  } dwps_state_type;

  // Per-update fetch of the two channel codes
  typedef enum logic [1:0] {
    FE_IDLE,
    FE_CH0,
    FE_CH1,
    FE_DONE
  } dwps_fetch_type;

endpackage

//--- core/dwps_sample_store.sv
`timescale 1ns/1ps
`include "dwps_consts.svh"

module dwps_sample_store #(
  parameter int DEPTH = `DWPS_FIFO_DEPTH
) (
  input  wire logic                  clk_sys,
  input  wire logic                  resetn,
  input  wire logic                  clear,
  input  wire logic                  replay,
  input  wire logic                  wrValid,
  input  wire dwps_pkg::dwps_code_type wrData,
  output logic                       wrReady,
  input  wire logic                  rdReq,
  output logic                       rdAvail,
  output dwps_pkg::dwps_code_type    rdData
);
  import dwps_pkg::*;

  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = $clog2(DEPTH + 1);

  dwps_code_type    mem [DEPTH];     // Sample storage
  logic [PTR_W-1:0] wrPtr;           // Next slot to fill
  logic [PTR_W-1:0] rdPtr;           // Next slot to play
  logic [CNT_W-1:0] count;           // Held samples, or pattern length in replay
  logic [CNT_W-1:0] next_count;
  logic             wrFire;
  logic             rdFire;
  logic             rdWrap;

  assign rdAvail = (count != '0);
  assign wrFire  = wrValid && wrReady;
  assign rdFire  = rdReq && rdAvail;
  // Replay wraps at the pattern end, so a short update count walks on
  assign rdWrap  = replay ? (CNT_W'(rdPtr) + CNT_W'(1) == count)
                          : (rdPtr == PTR_W'(DEPTH - 1));

  // Replay keeps played samples; streaming frees them for the host to refill
  always_comb begin
    next_count = count;
    if (wrFire) begin
      next_count = next_count + CNT_W'(1);
    end
    if (rdFire && !replay) begin
      next_count = next_count - CNT_W'(1);
    end
  end

  // Pointers, fill level and back-pressure toward the host
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wrPtr   <= '0;
      rdPtr   <= '0;
      count   <= '0;
      wrReady <= 1'b1;
    end else if (clear) begin
      wrPtr   <= '0;
      rdPtr   <= '0;
      count   <= '0;
      wrReady <= 1'b1;
    end else begin
      if (wrFire) begin
        wrPtr <= (wrPtr == PTR_W'(DEPTH - 1)) ? '0 : wrPtr + PTR_W'(1);
      end
      if (rdFire) begin
        rdPtr <= rdWrap ? '0 : rdPtr + PTR_W'(1);
      end
      count   <= next_count;
      wrReady <= (next_count < CNT_W'(DEPTH));
    end
  end

  // Storage array carries no reset so it can map to block memory
  always_ff @(posedge clk_sys) begin
    if (wrFire) begin
      mem[wrPtr] <= wrData;
    end
  end

  // Registered read port, one cycle behind the request
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rdData <= '0;
    end else if (rdFire) begin
      rdData <= mem[rdPtr];
    end
  end

endmodule // dwps_sample_store

//--- core/dwps_sequencer.sv
`timescale 1ns/1ps
`include "dwps_consts.svh"

module dwps_sequencer #(
  parameter int DEPTH = `DWPS_FIFO_DEPTH
) (
  input  wire logic                    clk_sys,
  input  wire logic                    resetn,
  input  wire logic                    softwareStart,
  input  wire logic                    triggerReset,
  input  wire logic                    counterReset,
  input  wire logic                    externalTriggerSource,
  input  wire logic                    triggerFalling,
  input  wire logic                    delayedMode,
  input  wire logic                    retriggerEnable,
  input  wire logic                    iterationEnable,
  input  wire logic                    chan0Enable,
  input  wire logic                    chan1Enable,
  input  wire logic                    replayMode,
  input  wire logic                    storeClear,
  input  wire logic [31:0]             updateIntervalCount,
  input  wire logic [31:0]             samplesPerPeriodCount,
  input  wire logic [31:0]             iterationCount,
  input  wire logic [31:0]             startDelayCount,
  input  wire logic [31:0]             interIterationDelayCount,
  input  wire logic [31:0]             triggerLimitCount,
  input  wire logic                    outputTriggerInput,
  input  wire logic                    sampleValid,
  input  wire dwps_pkg::dwps_code_type sampleData,
  output logic                         sampleReady,
  output dwps_pkg::dwps_code_type      dac0Code,
  output dwps_pkg::dwps_code_type      dac1Code,
  output logic                         converterWriteStrobe,
  output logic                         waveformActiveFlag,
  output logic                         triggerArmed,
  output logic                         underrunFlag
);
  import dwps_pkg::*;

  // Count one timebase period down, holding at zero
  function automatic logic [31:0] dwps_dec(input logic [31:0] v);
    return (v == '0) ? '0 : v - 32'h0000_0001;
  endfunction

  logic [`DWPS_ACC_W-1:0]  tbAcc;        // Fractional phase of the timebase
  logic                    tick;         // One timebase period elapsed
  logic                    trigSync1;    // Synchroniser, first stage
  logic                    trigSync2;    // Synchroniser, second stage
  logic                    trigLevel;    // Filtered trigger level
  logic                    trigLevelDly; // Filtered level one cycle back
  logic [`DWPS_FILT_W-1:0] filtCnt;      // Samples the new level has held
  logic                    extEdge;
  logic                    trigEvent;
  logic                    canAccept;
  logic                    trigAccept;
  logic [31:0]             acceptedCount;
  dwps_state_type          state;
  logic [31:0]             delayCnt;     // Shared by start and inter-iteration delay
  logic [31:0]             intervalCnt;  // Timebase periods to the next update
  logic [31:0]             sampleCnt;    // Updates done in this period
  logic [31:0]             iterCnt;      // Periods done in this sequence
  logic [31:0]             intervalUse;
  logic                    fire;
  logic                    lastSample;
  logic                    lastIter;
  logic                    periodEnd;
  logic                    seqEnd;
  dwps_fetch_type          fetch;
  logic                    got0;
  logic                    got1;
  dwps_code_type           hold0;
  dwps_code_type           rdData;
  logic                    rdAvail;
  logic                    rdReq;

  // Fractional divider: 80 of every 200 system cycles carry a tick
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tbAcc <= '0;
      tick  <= 1'b0;
    end else if (tbAcc + `DWPS_ACC_W'(`DWPS_TB_MHZ) >= `DWPS_ACC_W'(`DWPS_SYS_MHZ)) begin
      tbAcc <= tbAcc + `DWPS_ACC_W'(`DWPS_TB_MHZ) - `DWPS_ACC_W'(`DWPS_SYS_MHZ);
      tick  <= 1'b1;
    end else begin
      tbAcc <= tbAcc + `DWPS_ACC_W'(`DWPS_TB_MHZ);
      tick  <= 1'b0;
    end
  end

  // Two-stage synchroniser for the trigger pin
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      trigSync1 <= 1'b0;
      trigSync2 <= 1'b0;
    end else begin
      trigSync1 <= outputTriggerInput;
      trigSync2 <= trigSync1;
    end
  end

  // Glitch filter sized to the shortest legal pulse
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      trigLevel    <= 1'b0;
      trigLevelDly <= 1'b0;
      filtCnt      <= '0;
    end else begin
      trigLevelDly <= trigLevel;
      if (trigSync2 == trigLevel) begin
        filtCnt <= '0;
      end else if (filtCnt == `DWPS_FILT_W'(`DWPS_TRIG_FILT_CYC - 1)) begin
        trigLevel <= trigSync2;
        filtCnt   <= '0;
      end else begin
        filtCnt <= filtCnt + `DWPS_FILT_W'(1);
      end
    end
  end

  // Edge of chosen polarity, or the software command
  assign extEdge    = (trigLevel != trigLevelDly) && (trigLevel == !triggerFalling);
  assign trigEvent  = externalTriggerSource ? extEdge : softwareStart;
  // Only an idle, armed sequencer takes a trigger
  assign canAccept  = (state == DW_IDLE) && triggerArmed && !counterReset && !triggerReset;
  assign trigAccept = trigEvent && canAccept;

  // Arming: one trigger, or up to the limit when retriggering
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      triggerArmed  <= 1'b1;
      acceptedCount <= '0;
    end else if (triggerReset) begin
      triggerArmed  <= 1'b1;
      acceptedCount <= '0;
    end else if (trigAccept) begin
      acceptedCount <= acceptedCount + 32'h0000_0001;
      if (!retriggerEnable || (acceptedCount + 32'h0000_0001 >= triggerLimitCount)) begin
        triggerArmed <= 1'b0;
      end
    end
  end

  // Interval never below the minimum, capping the rate at 1 MHz except across an inter-iteration delay
  assign intervalUse = (updateIntervalCount < `DWPS_MIN_INTERVAL) ? `DWPS_MIN_INTERVAL
                                                                   : updateIntervalCount;
  // An update waits for the previous fetch so codes never mix
  assign fire       = (state == DW_RUN) && tick && (intervalCnt == '0) && (fetch == FE_IDLE);
  assign lastSample = (sampleCnt + 32'h0000_0001 >= samplesPerPeriodCount);
  assign lastIter   = iterationEnable && (iterCnt + 32'h0000_0001 >= iterationCount);
  assign periodEnd  = fire && lastSample;
  assign seqEnd     = periodEnd && lastIter;

  // Sequence state: delays, update pacing, periods and iterations
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state       <= DW_IDLE;
      delayCnt    <= '0;
      intervalCnt <= '0;
      sampleCnt   <= '0;
      iterCnt     <= '0;
    end else if (counterReset) begin
      state <= DW_IDLE; // Only way out of an unbounded run
    end else begin
      unique case (state)
        DW_IDLE: begin
          sampleCnt   <= '0;
          iterCnt     <= '0;
          intervalCnt <= '0;
          if (trigAccept) begin
            if (delayedMode) begin
              state    <= DW_DELAY1;
              delayCnt <= startDelayCount;
            end else begin
              state <= DW_RUN;
            end
          end
        end
        DW_DELAY1, DW_DELAY2: begin
          // Both delays count timebase periods down to zero
          if (tick) begin
            if (delayCnt == '0) begin
              state       <= DW_RUN;
              intervalCnt <= '0;
            end else begin
              delayCnt <= dwps_dec(delayCnt);
            end
          end
        end
        DW_RUN: begin
          if (fire) begin
            intervalCnt <= intervalUse - 32'h0000_0001;
            if (!lastSample) begin
              sampleCnt <= sampleCnt + 32'h0000_0001;
            end else begin
              sampleCnt <= '0;
              iterCnt   <= iterCnt + 32'h0000_0001;
              if (lastIter) begin
                state <= DW_IDLE;
              end else if (interIterationDelayCount != '0) begin
                state    <= DW_DELAY2;
                delayCnt <= interIterationDelayCount;
              end
            end
          end else if (tick && (intervalCnt != '0)) begin
            intervalCnt <= dwps_dec(intervalCnt);
          end
        end
      endcase
    end
  end

  // Active from accepted trigger until the last period ends
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      waveformActiveFlag <= 1'b0;
    end else if (trigAccept) begin
      waveformActiveFlag <= 1'b1;
    end else if (seqEnd || counterReset) begin
      waveformActiveFlag <= 1'b0;
    end
  end

  // Disabled channels take no sample, so the queue holds only enabled ones
  assign rdReq = ((fetch == FE_CH0) && chan0Enable) || ((fetch == FE_CH1) && chan1Enable);

  dwps_sample_store #(
    .DEPTH (DEPTH)
  ) u_store (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .clear   (storeClear),
    .replay  (replayMode),
    .wrValid (sampleValid),
    .wrData  (sampleData),
    .wrReady (sampleReady),
    .rdReq   (rdReq),
    .rdAvail (rdAvail),
    .rdData  (rdData)
  );

  // Fetch channel zero, then channel one, then strobe both codes out
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      fetch <= FE_IDLE;
      got0  <= 1'b0;
      got1  <= 1'b0;
      hold0 <= '0;
    end else begin
      unique case (fetch)
        FE_IDLE: begin
          if (fire) begin
            fetch <= FE_CH0;
          end
        end
        FE_CH0: begin
          got0  <= chan0Enable && rdAvail;
          fetch <= FE_CH1;
        end
        FE_CH1: begin
          if (got0) begin
            hold0 <= rdData;
          end
          got1  <= chan1Enable && rdAvail;
          fetch <= FE_DONE;
        end
        FE_DONE: begin
          fetch <= FE_IDLE;
        end
      endcase
    end
  end

  // Codes leave signed; a channel without fresh data holds its last code
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      dac0Code             <= '0;
      dac1Code             <= '0;
      converterWriteStrobe <= 1'b0;
    end else begin
      converterWriteStrobe <= (fetch == FE_DONE);
      if (fetch == FE_DONE) begin
        if (got0) begin
          dac0Code <= hold0;
        end
        if (got1) begin
          dac1Code <= rdData;
        end
      end
    end
  end

  // Underrun when the host failed to refill in time; a new miss beats the clear
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      underrunFlag <= 1'b0;
    end else if (rdReq && !rdAvail) begin
      underrunFlag <= 1'b1;
    end else if (counterReset) begin
      underrunFlag <= 1'b0;
    end
  end

  default clocking cbSys @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  sequence seqAccept;
    trigAccept && !counterReset;
  endsequence

  sequence seqRunEntry;
    state == DW_RUN;
  endsequence

  chk_active_set: assert property (seqAccept |=> waveformActiveFlag)
    else $error("active flag not set after accepted trigger");
  chk_busy_ignore: assert property (waveformActiveFlag && trigEvent |-> !trigAccept)
    else $error("trigger accepted during generation");
  chk_sw_start: assert property (canAccept && !externalTriggerSource && softwareStart
    |=> waveformActiveFlag && state != DW_IDLE)
    else $error("software start did not trigger");
  chk_post_direct: assert property (seqAccept ##0 !delayedMode |=> seqRunEntry)
    else $error("post trigger did not start at once");
  chk_delay_first: assert property (seqAccept ##0 delayedMode
    |=> state == DW_DELAY1 && delayCnt == $past(startDelayCount))
    else $error("start delay not loaded");
  chk_delay_end: assert property (state == DW_DELAY1 && tick && delayCnt == '0
    && !counterReset |=> seqRunEntry)
    else $error("run did not follow start delay");
  chk_gap_load: assert property (periodEnd && !lastIter && !counterReset
    && interIterationDelayCount != '0
    |=> state == DW_DELAY2 && delayCnt == $past(interIterationDelayCount))
    else $error("inter-iteration delay not loaded");
  chk_limit_disarm: assert property (trigAccept && retriggerEnable
    && acceptedCount + 32'h0000_0001 >= triggerLimitCount |=> !triggerArmed)
    else $error("trigger limit not enforced");
  chk_counter_stop: assert property (counterReset |=> state == DW_IDLE
    && !waveformActiveFlag)
    else $error("counter reset did not stop generation");
  chk_update_strobe: assert property (fire |-> ##4 converterWriteStrobe)
    else $error("update strobe not four cycles after update");
  chk_strobe_gap: assert property (converterWriteStrobe |=> !converterWriteStrobe [*3])
    else $error("write strobes too close");
  chk_period_bound: assert property (state == DW_RUN |->
    sampleCnt < samplesPerPeriodCount || samplesPerPeriodCount == '0)
    else $error("period exceeded update count");
  chk_iter_bound: assert property (iterationEnable && iterationCount != '0
    && state != DW_IDLE |-> iterCnt < iterationCount)
    else $error("iterations exceeded");

endmodule // dwps_sequencer

//--- testbench/dwps_host_model.sv
`timescale 1ns/1ps
module dwps_host_model #(
  parameter logic [63:0] PAT = 64'h0
) (
  input  wire logic               clk_sys,
  input  wire logic               resetn,
  input  wire logic               load,
  input  wire logic               sampleReady,
  output logic                    sampleValid,
  output dwps_pkg::dwps_code_type sampleData,
  output logic                    loadDone
);
  import dwps_pkg::*;
  logic [2:0] idx; // Next word to hand over
  assign loadDone = (idx == 3'h4);
  // Words go ch0 then ch1 per update; one load serves every replay
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      idx <= 3'h0;
      sampleValid <= 1'b0;
      sampleData <= '0;
    end else if (sampleValid && sampleReady) begin
      idx <= idx + 3'h1;
      sampleValid <= (idx != 3'h3);
      // Released data line shows no stale word
      sampleData <= (idx == 3'h3) ? ~sampleData : PAT[47 - 16 * idx -: 16];
    end else if (load && !sampleValid && idx == 3'h0) begin
      sampleValid <= 1'b1;
      sampleData <= PAT[63 -: 16];
    end
  end
endmodule // dwps_host_model

//--- testbench/dac_waveform_playback_sequencer_bench.sv
`timescale 1ns/1ps
module dac_waveform_playback_sequencer_bench;
  import dwps_pkg::*;
  localparam logic [63:0] PAT = 64'h8000_7fff_0001_ffff; // Both code extremes
  logic          clk_sys = 1'b0;
  logic          resetn = 1'b0;
  logic          swStart = 1'b0, trigRst = 1'b0, cntRst = 1'b0, extSrc = 1'b0;
  logic          falling = 1'b0, delayed = 1'b0, retrig = 1'b0, iterEn = 1'b1;
  logic          pin = 1'b0, load = 1'b0, ch1En = 1'b1;
  localparam int SW = 0, TRG = 1, CNT = 2; // Command pulse selectors
  logic          loadDone, sampleValid, sampleReady, strobe, active, armed, underrun;
  logic [31:0]   ui = 32'h50, uc = 32'h3, ic = 32'h2, d1 = 32'h0, d2 = 32'h0, lim = 32'h1;
  dwps_code_type sampleData, dac0, dac1;
  dwps_code_type q0[$], q1[$]; // Codes seen at each strobe
  int            tq[$];        // Cycle of each strobe
  int            cyc = 0, err_total = 0, compares = 0;

  // Free-running clock, 5 ns
  initial forever #2.5 clk_sys = ~clk_sys;

  dwps_host_model #(.PAT(PAT)) dwps_host_model_inst (.clk_sys(clk_sys), .resetn(resetn),
    .load(load), .sampleReady(sampleReady), .sampleValid(sampleValid),
    .sampleData(sampleData), .loadDone(loadDone));

  // Small store so that filling it to refusal is quick
  dwps_sequencer #(.DEPTH(4)) dwps_sequencer_inst (.clk_sys(clk_sys), .resetn(resetn),
    .softwareStart(swStart), .triggerReset(trigRst), .counterReset(cntRst),
    .externalTriggerSource(extSrc), .triggerFalling(falling), .delayedMode(delayed),
    .retriggerEnable(retrig), .iterationEnable(iterEn), .chan0Enable(1'b1),
    .chan1Enable(ch1En), .replayMode(1'b1), .storeClear(1'b0), .updateIntervalCount(ui),
    .samplesPerPeriodCount(uc), .iterationCount(ic), .startDelayCount(d1),
    .interIterationDelayCount(d2), .triggerLimitCount(lim), .outputTriggerInput(pin),
    .sampleValid(sampleValid), .sampleData(sampleData), .sampleReady(sampleReady),
    .dac0Code(dac0), .dac1Code(dac1), .converterWriteStrobe(strobe),
    .waveformActiveFlag(active), .triggerArmed(armed), .underrunFlag(underrun));

  // Strobe monitor records codes and times
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (strobe === 1'b1) begin
      q0.push_back(dac0);
      q1.push_back(dac1);
      tq.push_back(cyc);
    end
  end

  function automatic dwps_code_type pat(int i);
    return PAT[63 - 16 * (i % 4) -: 16];
  endfunction

  task automatic tally_and_finish;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic cmp_bit(string what, logic exp, logic got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic cmp_code(string what, dwps_code_type exp, dwps_code_type got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  // Bench-side counts and times lie in a range
  task automatic cmp_range(string what, int lo, int hi, int got);
    compares++;
    if (got < lo || got > hi) begin
      err_total++;
      $display("unexpected %s: expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask

  task automatic tick(int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // One-cycle command pulse; a selector keeps the drive off a reference argument
  task automatic pulse(int which);
    case (which)
      SW:      swStart <= 1'b1;
      TRG:     trigRst <= 1'b1;
      default: cntRst <= 1'b1;
    endcase
    tick(1);
    swStart <= 1'b0;
    trigRst <= 1'b0;
    cntRst <= 1'b0;
  endtask

  // Pin idles at the inactive level, pulse lasts 40 ns
  task automatic fire_ext(logic fall);
    falling <= fall;
    pin <= fall;
    tick(10);
    pin <= ~fall;
    tick(8);
    pin <= fall;
  endtask

  // Bounded wait for the sequence to end
  task automatic wait_idle(int limit);
    int i;
    for (i = 0; i < limit && active !== 1'b0; i++) tick(1);
    if (i == limit) begin
      err_total++;
      $display("unexpected wait: expected idle seen busy");
      tally_and_finish;
    end else begin
      // Flag drops at the last update; its strobe follows four cycles on
      tick(6);
    end
  endtask

  task automatic test_load;
    int i;
    load <= 1'b1;
    for (i = 0; i < 40 && loadDone !== 1'b1; i++) tick(1);
    if (i == 40) begin
      err_total++;
      $display("unexpected load: expected done seen busy");
      tally_and_finish;
    end else begin
      tick(2);
    end
    cmp_bit("sampleReady", 1'b0, sampleReady);
    $display("test load done");
  endtask

  task automatic test_post;
    int n0;
    int t0;
    n0 = tq.size();
    t0 = cyc;
    pulse(SW);
    tick(2);
    cmp_bit("active", 1'b1, active);
    tick(300);
    pulse(SW);
    wait_idle(3000);
    cmp_range("strobes", 6, 6, tq.size() - n0);
    cmp_range("latency", 0, 14, tq[n0] - t0);
    for (int k = 0; k < 6; k++) begin
      cmp_code("dac0", pat(2 * k), q0[n0 + k]);
      cmp_code("dac1", pat(2 * k + 1), q1[n0 + k]);
      if (k > 0) cmp_range("gap", 200, 200, tq[n0 + k] - tq[n0 + k - 1]);
    end
    cmp_bit("armed", 1'b0, armed);
    pulse(SW);
    tick(300);
    cmp_range("strobes", 6, 6, tq.size() - n0);
    pulse(TRG);
    tick(2);
    cmp_bit("armed", 1'b1, armed);
    $display("test post done");
  endtask

  task automatic test_delay;
    int n0;
    int t0;
    uc <= 32'h1;
    d1 <= 32'h28;
    d2 <= 32'h14;
    delayed <= 1'b1;
    retrig <= 1'b1;
    lim <= 32'h2;
    extSrc <= 1'b1;
    tick(2);
    n0 = tq.size();
    t0 = cyc;
    fire_ext(1'b0);
    wait_idle(3000);
    cmp_range("strobes", 2, 2, tq.size() - n0);
    cmp_range("start delay", 110, 140, tq[n0] - t0);
    cmp_range("iter delay", 50, 62, tq[n0 + 1] - tq[n0]);
    fire_ext(1'b1);
    wait_idle(3000);
    cmp_range("strobes", 4, 4, tq.size() - n0);
    cmp_bit("armed", 1'b0, armed);
    fire_ext(1'b1);
    tick(300);
    cmp_range("strobes", 4, 4, tq.size() - n0);
    pulse(TRG);
    $display("test delay done");
  endtask

  task automatic test_forever;
    int n0;
    delayed <= 1'b0;
    retrig <= 1'b0;
    extSrc <= 1'b0;
    iterEn <= 1'b0;
    ic <= 32'h1;
    d2 <= 32'h0;
    tick(2);
    n0 = tq.size();
    pulse(SW);
    tick(1500);
    cmp_range("strobes", 7, 8, tq.size() - n0);
    cmp_bit("active", 1'b1, active);
    pulse(CNT);
    tick(8);
    cmp_bit("active", 1'b0, active);
    cmp_bit("underrun", 1'b0, underrun);
    $display("test forever done");
  endtask

  // Channel one disabled: it takes no words and keeps its last code
  task automatic test_single;
    int n0;
    int j;
    ch1En <= 1'b0;
    iterEn <= 1'b1;
    uc <= 32'h2;
    pulse(TRG);
    tick(2);
    n0 = tq.size();
    j = 0;
    pulse(SW);
    tick(2);
    wait_idle(3000);
    cmp_range("strobes", 2, 2, tq.size() - n0);
    while (j < 3 && pat(j) !== q0[n0]) j++;
    cmp_code("dac0", pat(j + 1), q0[n0 + 1]);
    cmp_code("dac1", q1[n0 - 1], q1[n0]);
    cmp_code("dac1", q1[n0 - 1], q1[n0 + 1]);
    $display("test single done");
  endtask

  // Main sequence
  initial begin
    tick(15);
    cmp_bit("strobe", 1'b0, strobe);
    cmp_bit("armed", 1'b1, armed);
    cmp_code("dac0", 16'h0000, dac0);
    tick(1);
    resetn <= 1'b1;
    tick(1);
    test_load;
    test_post;
    test_delay;
    test_forever;
    test_single;
    tally_and_finish;
  end
endmodule // dac_waveform_playback_sequencer_bench
